// [hw/fcp_chan.v]
`timescale 1ns/100ps
`default_nettype none

`include "fcp_defines.vh"

module fcp_chan #(
    parameter CNT_W = `FCP_CNT_W
) (
    input wire sys_clk,
    input wire rst_n,
    input wire tick,
    input wire start,
    input wire stop,
    input wire [CNT_W-1:0] period,
    input wire [CNT_W-1:0] duty,
    output reg running_q,
    output reg level_q
);

    // ----------------------------------------
    // counters
    // ----------------------------------------
    reg [CNT_W-1:0] per_cnt_q;
    reg [CNT_W-1:0] duty_cnt_q;
    wire duty_nz;

    assign duty_nz = (duty != {CNT_W{1'b0}});

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            per_cnt_q <= `FCP_RST_PERIOD;
            duty_cnt_q <= `FCP_RST_DUTY;
            running_q <= 1'b0;
            level_q <= 1'b0;
        end else if (stop) begin
            // stopped: inactive, counters back to initial values
            running_q <= 1'b0;
            level_q <= 1'b0;
            per_cnt_q <= period;
            duty_cnt_q <= duty;
        end else if (start) begin
            // both counters loaded together, output goes active unless duty is zero
            running_q <= 1'b1;
            per_cnt_q <= period;
            duty_cnt_q <= duty;
            level_q <= duty_nz;
        end else if (running_q && tick) begin
            if (per_cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                // period end: reload both, active again unless duty is zero
                per_cnt_q <= period;
                duty_cnt_q <= duty;
                level_q <= duty_nz;
            end else begin
                per_cnt_q <= per_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
                if (duty_cnt_q != {CNT_W{1'b0}}) begin
                    duty_cnt_q <= duty_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
                end
                if (duty_cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    // duty counter halts, output inactive for the rest
                    level_q <= 1'b0;
                end
            end
        end
    end

endmodule

`default_nettype wire

// [hw/fcp_defines.vh]
`ifndef FCP_DEFINES_VH
`define FCP_DEFINES_VH

// ----------------------------------------
// command codes
// ----------------------------------------
`define FCP_CMD_STOP 4'h0
`define FCP_CMD_LOAD 4'h1
`define FCP_CMD_POL 4'h2
`define FCP_CMD_GATE 4'h3
`define FCP_CMD_RESET 4'h4
`define FCP_CMD_ROUTE 4'h5
`define FCP_CMD_CLKSEL 4'h6
`define FCP_CMD_START 4'h7

// ----------------------------------------
// geometry
// ----------------------------------------
`define FCP_NUM_CHAN 4
`define FCP_CNT_W 24
`define FCP_PORT_W 8
`define FCP_PIN_BASE 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define FCP_RST_PERIOD 24'h000000
`define FCP_RST_DUTY 24'h000000
`define FCP_RST_POL 1'b1
`define FCP_RST_CLKSEL 1'b0

// ----------------------------------------
// timing: fast source ticks every cycle, slow source is divided
// ----------------------------------------
`define FCP_FAST_MHZ 50
`define FCP_SLOW_MHZ 1
`define FCP_SLOW_DIV (`FCP_FAST_MHZ / `FCP_SLOW_MHZ)
`define FCP_DIV_W 6

`endif

// [hw/fcp_pwm_unit.v]
// Notes on behaviour
// - four channels, 24-bit period and duty counters
// - up to 25MHz, 0-100% duty, constant extremes
// - start loads both counters, output goes active
// - duty zero halts duty count, output inactive
// - period zero reloads both, output active again
// - duty writable while running, no restart
// - config single channel; start/stop/reset allow all
// - stop forces inactive and reloads counters
// - load writes period or duty value
// - polarity select; inactive is opposite level
// - gate off holds pin at inactive level
// - route drives port C pin as output
// - reset stops, releases pin to ordinary use
// - clock select fast or slow, per channel
// - start launches selected channels same edge
// - channel n drives port C bit 4+n
`timescale 1ns/100ps
`default_nettype none

`include "fcp_defines.vh"

module fcp_pwm_unit #(
    parameter NUM_CHAN = `FCP_NUM_CHAN,
    parameter CNT_W = `FCP_CNT_W,
    parameter PORT_W = `FCP_PORT_W
) (
    input wire sys_clk,
    input wire rst_n,
    input wire cmd_valid,
    input wire [3:0] cmd_code,
    input wire [1:0] cmd_chan,
    input wire cmd_all,
    input wire cmd_sel_duty,
    input wire cmd_flag,
    input wire [CNT_W-1:0] cmd_value,
    input wire [PORT_W-1:0] dio_c_dir,
    input wire [PORT_W-1:0] dio_c_data,
    output reg cmd_ack_q,
    output reg cmd_err_q,
    output reg [PORT_W-1:0] pin_c_o_q,
    output reg [PORT_W-1:0] pin_c_oe_q,
    output reg [NUM_CHAN-1:0] chan_running_q,
    output reg [NUM_CHAN-1:0] chan_routed_q,
    output reg [NUM_CHAN-1:0] chan_gated_q,
    output reg [NUM_CHAN-1:0] chan_level_q
);

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    function [NUM_CHAN-1:0] chan_mask;
        input [1:0] chan;
        input all;
        begin
            if (all) begin
                chan_mask = {NUM_CHAN{1'b1}};
            end else begin
                chan_mask = {{(NUM_CHAN-1){1'b0}}, 1'b1} << chan;
            end
        end
    endfunction

    function pin_level;
        input pulse;
        input gate;
        input pol;
        begin
            if (gate && pulse) begin
                pin_level = pol;
            end else begin
                pin_level = ~pol;
            end
        end
    endfunction

    function tick_src;
        input sel;
        input slow;
        begin
            if (sel) begin
                tick_src = slow;
            end else begin
                tick_src = 1'b1;
            end
        end
    endfunction

    // ----------------------------------------
    // per-channel configuration
    // ----------------------------------------
    reg [CNT_W-1:0] period_q [0:NUM_CHAN-1];
    reg [CNT_W-1:0] duty_q [0:NUM_CHAN-1];
    reg [NUM_CHAN-1:0] pol_q;
    reg [NUM_CHAN-1:0] clksel_q;
    reg [NUM_CHAN-1:0] gate_q;
    reg [NUM_CHAN-1:0] route_q;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    reg [NUM_CHAN-1:0] mask_d;
    reg is_group_cmd;
    reg is_cfg_cmd;
    reg cmd_ok_d;
    reg cmd_err_d;
    reg [NUM_CHAN-1:0] start_d;
    reg [NUM_CHAN-1:0] stop_d;
    reg [NUM_CHAN-1:0] reset_d;

    always @* begin
        mask_d = chan_mask(cmd_chan, cmd_all);
        is_group_cmd = 1'b0;
        is_cfg_cmd = 1'b0;
        case (cmd_code)
            `FCP_CMD_STOP: begin
                is_group_cmd = 1'b1;
            end
            `FCP_CMD_START: begin
                is_group_cmd = 1'b1;
            end
            `FCP_CMD_RESET: begin
                is_group_cmd = 1'b1;
            end
            `FCP_CMD_LOAD: begin
                is_cfg_cmd = 1'b1;
            end
            `FCP_CMD_POL: begin
                is_cfg_cmd = 1'b1;
            end
            `FCP_CMD_GATE: begin
                is_cfg_cmd = 1'b1;
            end
            `FCP_CMD_ROUTE: begin
                is_cfg_cmd = 1'b1;
            end
            `FCP_CMD_CLKSEL: begin
                is_cfg_cmd = 1'b1;
            end
            default: begin
                is_group_cmd = 1'b0;
            end
        endcase
        // configuration aimed at all channels is refused
        cmd_ok_d = cmd_valid && (is_group_cmd || (is_cfg_cmd && !cmd_all));
        cmd_err_d = cmd_valid && !cmd_ok_d;
        start_d = {NUM_CHAN{1'b0}};
        stop_d = {NUM_CHAN{1'b0}};
        reset_d = {NUM_CHAN{1'b0}};
        if (cmd_ok_d) begin
            if (cmd_code == `FCP_CMD_START) begin
                start_d = mask_d;
            end
            if (cmd_code == `FCP_CMD_STOP) begin
                stop_d = mask_d;
            end
            if (cmd_code == `FCP_CMD_RESET) begin
                reset_d = mask_d;
            end
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    integer i;

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            for (i = 0; i < NUM_CHAN; i = i + 1) begin
                period_q[i] <= `FCP_RST_PERIOD;
                duty_q[i] <= `FCP_RST_DUTY;
            end
            pol_q <= {NUM_CHAN{`FCP_RST_POL}};
            clksel_q <= {NUM_CHAN{`FCP_RST_CLKSEL}};
            gate_q <= {NUM_CHAN{1'b0}};
            route_q <= {NUM_CHAN{1'b0}};
        end else if (cmd_ok_d) begin
            case (cmd_code)
                `FCP_CMD_LOAD: begin
                    // duty may change while running; takes hold at next reload
                    if (cmd_sel_duty) begin
                        duty_q[cmd_chan] <= cmd_value;
                    end else begin
                        period_q[cmd_chan] <= cmd_value;
                    end
                end
                `FCP_CMD_POL: begin
                    pol_q[cmd_chan] <= cmd_flag;
                end
                `FCP_CMD_GATE: begin
                    gate_q[cmd_chan] <= cmd_flag;
                end
                `FCP_CMD_ROUTE: begin
                    route_q[cmd_chan] <= cmd_flag;
                end
                `FCP_CMD_CLKSEL: begin
                    clksel_q[cmd_chan] <= cmd_flag;
                end
                `FCP_CMD_RESET: begin
                    route_q <= route_q & ~mask_d;
                    gate_q <= gate_q & ~mask_d;
                end
                default: begin
                    route_q <= route_q;
                end
            endcase
        end
    end

    // ----------------------------------------
    // slow clock source divider
    // ----------------------------------------
    // terminal count cut to the divider width
    localparam integer DIV_LAST_I = `FCP_SLOW_DIV - 1;
    localparam [`FCP_DIV_W-1:0] DIV_LAST = DIV_LAST_I[`FCP_DIV_W-1:0];
    localparam [`FCP_DIV_W-1:0] DIV_ONE = {{(`FCP_DIV_W-1){1'b0}}, 1'b1};

    reg [`FCP_DIV_W-1:0] div_q;
    reg slow_tick_q;
    wire div_wrap_w;

    assign div_wrap_w = (div_q == DIV_LAST);

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            div_q <= {`FCP_DIV_W{1'b0}};
            slow_tick_q <= 1'b0;
        end else if (div_wrap_w) begin
            div_q <= {`FCP_DIV_W{1'b0}};
            slow_tick_q <= 1'b1;
        end else begin
            div_q <= div_q + DIV_ONE;
            slow_tick_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // channels
    // ----------------------------------------
    wire [NUM_CHAN-1:0] run_w;
    wire [NUM_CHAN-1:0] lvl_w;
    wire [NUM_CHAN-1:0] tick_w;

    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g = g + 1) begin : gen_chan
            // both counters of a channel share one tick source
            assign tick_w[g] = tick_src(clksel_q[g], slow_tick_q);

            fcp_chan #(
                .CNT_W(CNT_W)
            ) u_chan (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .tick(tick_w[g]),
                .start(start_d[g]),
                .stop(stop_d[g] | reset_d[g]),
                .period(period_q[g]),
                .duty(duty_q[g]),
                .running_q(run_w[g]),
                .level_q(lvl_w[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // per-channel pin drive
    // ----------------------------------------
    wire [NUM_CHAN-1:0] drv_w;

    generate
        for (g = 0; g < NUM_CHAN; g = g + 1) begin : gen_drv
            // gate off or inactive phase shows the opposite of the polarity
            assign drv_w[g] = pin_level(lvl_w[g], gate_q[g], pol_q[g]);
        end
    endgenerate

    // ----------------------------------------
    // port C pin mux
    // ----------------------------------------
    reg [PORT_W-1:0] pin_o_d;
    reg [PORT_W-1:0] pin_oe_d;
    integer k;

    always @* begin
        // unrouted pins keep the ordinary dio direction and data
        pin_o_d = dio_c_data;
        pin_oe_d = dio_c_dir;
        for (k = 0; k < NUM_CHAN; k = k + 1) begin
            if (route_q[k]) begin
                pin_oe_d[`FCP_PIN_BASE + k] = 1'b1;
                pin_o_d[`FCP_PIN_BASE + k] = drv_w[k];
            end
        end
    end

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_c_o_q <= {PORT_W{1'b0}};
            pin_c_oe_q <= {PORT_W{1'b0}};
        end else begin
            pin_c_o_q <= pin_o_d;
            pin_c_oe_q <= pin_oe_d;
        end
    end

    // ----------------------------------------
    // status outputs
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            chan_running_q <= {NUM_CHAN{1'b0}};
            chan_routed_q <= {NUM_CHAN{1'b0}};
            chan_gated_q <= {NUM_CHAN{1'b0}};
            chan_level_q <= {NUM_CHAN{1'b0}};
        end else begin
            chan_running_q <= run_w;
            chan_routed_q <= route_q;
            chan_gated_q <= gate_q;
            chan_level_q <= lvl_w;
        end
    end

    // ----------------------------------------
    // command answer
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            cmd_ack_q <= 1'b0;
            cmd_err_q <= 1'b0;
        end else begin
            cmd_ack_q <= cmd_ok_d;
            cmd_err_q <= cmd_err_d;
        end
    end

endmodule

`default_nettype wire

// [tb/fcp_pwm_unit_properties.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// command and pin checks
// ----------------------------------------
module fcp_pwm_unit_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic [1:0] cmd_chan,
    input wire logic cmd_all,
    input wire logic cmd_sel_duty,
    input wire logic cmd_flag,
    input wire logic [23:0] cmd_value,
    input wire logic [7:0] dio_c_dir,
    input wire logic [7:0] dio_c_data,
    input wire logic cmd_ack_q,
    input wire logic cmd_err_q,
    input wire logic [7:0] pin_c_o_q,
    input wire logic [7:0] pin_c_oe_q,
    input wire logic [3:0] chan_running_q,
    input wire logic [3:0] chan_routed_q,
    input wire logic [3:0] chan_gated_q,
    input wire logic [3:0] chan_level_q
);
    default clocking dck @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    wire logic cfg = (cmd_code == 4'h1) || (cmd_code == 4'h2) || (cmd_code == 4'h3) || (cmd_code == 4'h5)
        || (cmd_code == 4'h6);
    sequence s_good;
        cmd_valid && (cmd_code < 4'h8) && !(cmd_all && cfg);
    endsequence
    sequence s_bad;
        cmd_valid && ((cmd_code > 4'h7) || (cmd_all && cfg));
    endsequence
    property p_ack;
        s_good |=> cmd_ack_q && !cmd_err_q;
    endproperty
    a_ack: assert property (p_ack) else $error("accepted command not acknowledged");
    property p_err;
        s_bad |=> cmd_err_q && !cmd_ack_q;
    endproperty
    a_err: assert property (p_err) else $error("refused command not flagged");
    property p_idle;
        !cmd_valid |=> !cmd_ack_q && !cmd_err_q;
    endproperty
    a_idle: assert property (p_idle) else $error("answer without command");
    property p_start_all;
        cmd_valid && cmd_code == 4'h7 && cmd_all |-> ##[1:2] (chan_running_q == 4'hF);
    endproperty
    a_start_all: assert property (p_start_all) else $error("start all did not run all");
    property p_stop_all;
        cmd_valid && cmd_code == 4'h0 && cmd_all |-> ##[1:2] (chan_running_q == 4'h0 && chan_level_q == 4'h0);
    endproperty
    a_stop_all: assert property (p_stop_all) else $error("stop all left a channel active");
    property p_reset_all;
        cmd_valid && cmd_code == 4'h4 && cmd_all |-> ##[1:2] ((chan_routed_q | chan_gated_q | chan_running_q) == 4'h0);
    endproperty
    a_reset_all: assert property (p_reset_all) else $error("reset all left a channel claimed");
    property p_route;
        (chan_routed_q & $past(chan_routed_q) & ~pin_c_oe_q[7:4]) == 4'h0;
    endproperty
    a_route: assert property (p_route) else $error("routed pin not driven");
    property p_low_pass;
        $past(rst_n) |-> pin_c_oe_q[3:0] == $past(dio_c_dir[3:0]) && pin_c_o_q[3:0] == $past(dio_c_data[3:0]);
    endproperty
    a_low_pass: assert property (p_low_pass) else $error("lower port bits not passed through");
    property p_gate_off;
        (chan_routed_q[0] && !chan_gated_q[0] && !cmd_valid) [*3] |=> $stable(pin_c_o_q[4]);
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("ungated pin moved");
    property p_follow;
        (chan_routed_q[0] && chan_gated_q[0] && !cmd_valid) [*2] |=> $stable(pin_c_o_q[4] ^ chan_level_q[0]);
    endproperty
    a_follow: assert property (p_follow) else $error("gated pin not tracking level");
endmodule
`default_nettype wire

// [tb/tb_fcp_pwm_unit.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// pwm unit bench
// ----------------------------------------
module tb_fcp_pwm_unit;
    logic sys_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_all = 1'b0, cmd_sel_duty = 1'b0, cmd_flag = 1'b0;
    logic [3:0] cmd_code = 4'h0;
    logic [1:0] cmd_chan = 2'h0;
    logic [23:0] cmd_value = 24'h000000;
    logic [7:0] dio_c_dir = 8'hA5, dio_c_data = 8'h3C;
    wire logic cmd_ack_q, cmd_err_q;
    wire logic [7:0] pin_c_o_q, pin_c_oe_q;
    wire logic [3:0] chan_running_q, chan_routed_q, chan_gated_q, chan_level_q;
    int n_fail = 0, checked = 0, i, n;
    logic check_prev = 1'b0;
    fcp_pwm_unit dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_chan(cmd_chan), .cmd_all(cmd_all), .cmd_sel_duty(cmd_sel_duty), .cmd_flag(cmd_flag),
        .cmd_value(cmd_value), .dio_c_dir(dio_c_dir), .dio_c_data(dio_c_data), .cmd_ack_q(cmd_ack_q),
        .cmd_err_q(cmd_err_q), .pin_c_o_q(pin_c_o_q), .pin_c_oe_q(pin_c_oe_q), .chan_running_q(chan_running_q),
        .chan_routed_q(chan_routed_q), .chan_gated_q(chan_gated_q), .chan_level_q(chan_level_q));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        if (n_fail == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // f holds all, select duty, flag
    task cmd(input logic [3:0] c, input logic [1:0] ch, input logic [2:0] f, input logic [23:0] v);
        logic bad;
        bad = (c > 4'h7) || (f[2] && (c == 4'h1 || c == 4'h2 || c == 4'h3 || c == 4'h5 || c == 4'h6));
        {cmd_valid, cmd_code, cmd_chan, cmd_all, cmd_sel_duty, cmd_flag, cmd_value} = {1'b1, c, ch, f, v};
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        check({cmd_ack_q, cmd_err_q}, {!bad, bad});
        @(negedge sys_clk);
    endtask
    task wait_lvl(input int ch, input logic v);
        int k;
        for (k = 0; k < 400 && chan_level_q[ch] !== v; k++) @(negedge sys_clk);
        if (k == 400) begin
            n_fail++;
            report_and_stop;
        end
    endtask
    task wave(input logic [3:0] m, input logic [7:0] pat);
        int k;
        for (k = 0; k < 8; k++) begin
            check(chan_level_q & m, pat[7-k] ? m : 4'h0);
            @(negedge sys_clk);
        end
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        check({chan_running_q, chan_routed_q, chan_gated_q, chan_level_q}, 16'h0000);
        check({pin_c_oe_q, pin_c_o_q}, 16'hA53C);
        for (i = 8; i < 16; i++) cmd(i[3:0], 2'h0, 3'h0, 24'h000000);
        for (i = 1; i < 7; i++) cmd(i[3:0], 2'h1, 3'h5, 24'h000001);
        for (i = 0; i < 4; i++) begin
            cmd(4'h1, i[1:0], 3'h0, 24'h000004);
            cmd(4'h1, i[1:0], 3'h2, 24'h000002);
            cmd(4'h3, i[1:0], 3'h1, 24'h000000);
            cmd(4'h5, i[1:0], 3'h1, 24'h000000);
        end
        check({pin_c_oe_q, pin_c_o_q}, 16'hF50C);
        cmd(4'h7, 2'h0, 3'h4, 24'h000000);
        wait_lvl(0, 1'b1);
        check(pin_c_o_q[7:4], 4'hF);
        wave(4'hF, 8'hCC);
        cmd(4'h1, 2'h0, 3'h2, 24'h000003);
        check(chan_running_q[0], 1'b1);
        wait_lvl(0, 1'b0);
        wait_lvl(0, 1'b1);
        wave(4'h1, 8'hEE);
        cmd(4'h1, 2'h1, 3'h2, 24'h000000);
        cmd(4'h1, 2'h2, 3'h2, 24'h000009);
        repeat (8) @(negedge sys_clk);
        wave(4'h2, 8'h00);
        wave(4'h4, 8'hFF);
        cmd(4'h2, 2'h0, 3'h0, 24'h000000);
        for (i = 0; i < 4; i++) begin
            check(pin_c_o_q[4], !chan_level_q[0]);
            @(negedge sys_clk);
        end
        cmd(4'h3, 2'h0, 3'h0, 24'h000000);
        for (i = 0; i < 4; i++) begin
            check(pin_c_o_q[4], 1'b1);
            @(negedge sys_clk);
        end
        cmd(4'h0, 2'h0, 3'h0, 24'h000000);
        check({chan_running_q[0], chan_level_q[0], pin_c_o_q[4]}, 3'b001);
        cmd(4'h7, 2'h0, 3'h0, 24'h000000);
        wave(4'h1, 8'hEE);
        cmd(4'h6, 2'h1, 3'h1, 24'h000000);
        cmd(4'h1, 2'h1, 3'h2, 24'h000001);
        cmd(4'h1, 2'h1, 3'h0, 24'h000002);
        cmd(4'h7, 2'h1, 3'h0, 24'h000000);
        n = 0;
        for (i = 0; i < 200; i++) begin
            @(negedge sys_clk);
            check(pin_c_o_q[5], chan_level_q[1]);
            if (i > 0 && chan_level_q[1] !== check_prev) n++;
            check_prev = chan_level_q[1];
        end
        check((n >= 2) && (n <= 6), 1'b1);
        cmd(4'h0, 2'h0, 3'h4, 24'h000000);
        check({chan_running_q, chan_level_q}, 8'h00);
        cmd(4'h4, 2'h0, 3'h0, 24'h000000);
        check({chan_running_q[0], chan_routed_q[0], chan_gated_q[0], pin_c_oe_q[4], pin_c_o_q[4]}, 5'b00001);
        cmd(4'h4, 2'h0, 3'h4, 24'h000000);
        check({chan_running_q, chan_routed_q, chan_gated_q}, 12'h000);
        check(pin_c_oe_q, 8'hA5);
        check(pin_c_o_q, 8'h3C);
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        report_and_stop;
    end
endmodule
bind fcp_pwm_unit fcp_pwm_unit_checker chk (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_chan(cmd_chan), .cmd_all(cmd_all), .cmd_sel_duty(cmd_sel_duty),
    .cmd_flag(cmd_flag), .cmd_value(cmd_value), .dio_c_dir(dio_c_dir), .dio_c_data(dio_c_data),
    .cmd_ack_q(cmd_ack_q), .cmd_err_q(cmd_err_q), .pin_c_o_q(pin_c_o_q), .pin_c_oe_q(pin_c_oe_q),
    .chan_running_q(chan_running_q), .chan_routed_q(chan_routed_q), .chan_gated_q(chan_gated_q),
    .chan_level_q(chan_level_q));
`default_nettype wire
